//--- core/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
// mode field encodings
`define SSC_MODE_SPI_SS     4'h4
`define SSC_MODE_SPI_NOSS   4'h5
`define SSC_MODE_I2C_S7     4'h6
`define SSC_MODE_I2C_S10    4'h7
`define SSC_MODE_I2C_FWM    4'hB
`define SSC_MODE_I2C_S7_SP  4'hE
`define SSC_MODE_I2C_S10_SP 4'hF
// shifter
`define SSC_BIT_LAST        3'h7
`define SSC_BIT_ZERO        3'h0
`define SSC_BYTE_RST        8'h00
`endif

//--- core/ssc_pkg.sv
package ssc_pkg;
   typedef struct packed {
      logic [3:0] mode;          // port_control_one mode field
      logic       port_enable_bit;
      logic       clock_idle_polarity;
      logic       clock_edge_sel;
      logic       buffer_overwrite_enable;
      logic       start_irq_enable;
      logic       stop_irq_enable;
   } ssc_cfg_t;

   typedef struct packed {
      logic start_seen;
      logic stop_seen;
      logic bus_active;
      logic collision;
      logic prior_match;
   } ssc_i2c_stat_t;

   typedef enum logic [1:0] {
      SSC_BUS_IDLE  = 2'b00,
      SSC_BUS_BUSY  = 2'b01,
      SSC_BUS_START = 2'b10
   } ssc_bus_t;
endpackage : ssc_pkg

//--- core/ssc_top.sv
`timescale 1ns/100ps
`include "ssc_cfg.svh"
// Operation
// - slave shifts on each external clock pulse, flags byte done after last bit.
// - idle clock level chosen by polarity bit; master idles clock before enable.
// - shifting runs from external clock in sleep; byte interrupt wakes device.
// - daisy chain: second group of pulses returns exact copy of received bits.
// - overwrite enable lets software write buffer though last byte unread.
// - select-controlled slave entered only when mode field equals 0100.
// - select low in that mode enables transfer and drives data out.
// - select high releases data output at once, even mid byte.
// - select high or port disable resets shifter, bit counter to zero.
// - data falling while clock high is a Start; bus leaves idle.
// - collision flagged if data already low before device drives Start.
// - Stop is data rising with clock high, valid only after a clock low.
// - Restart acts like Start, resetting slave logic for an address.
// - 10-bit read after prior match: hold clock low, prepare transmit data.
// - prior match set on full write match; cleared by Stop or a high byte that is not a matched read.
// - start/stop irq enables add interrupts only in modes lacking them.
module ssc_top
   import ssc_pkg::*;
(
   input  wire logic                clock_i,        // system clock
   input  wire logic                rst_n_i,        // async reset, low
   input  wire ssc_pkg::ssc_cfg_t   cfg_i,          // static configuration
   input  wire logic                sleep_irq_en_i, // wake on byte interrupt
   input  wire logic                flag_clr_i,     // clear byte_done_flag
   input  wire logic                buf_wr_i,       // shift_buffer write strobe
   input  wire logic [7:0]          buf_wdata_i,    // shift_buffer write data
   input  wire logic                buf_rd_i,       // shift_buffer read strobe
   input  wire logic                sck_i,          // serial clock pin
   input  wire logic                ss_n_i,         // slave select pin
   input  wire logic                sdi_i,          // serial data in pin
   input  wire logic                scl_i,          // i2c clock pin level
   input  wire logic                sda_i,          // i2c data pin level
   input  wire logic                start_gen_i,    // request Start drive
   input  wire logic                sda_release_i,  // release driven data
   input  wire logic                bcol_clr_i,     // clear collision flag
   input  wire logic                full_match_i,   // 10-bit full address match
   input  wire logic                high_byte_i,    // high address byte received
   input  wire logic                high_match_i,   // high byte matched
   input  wire logic                rw_i,           // direction of that byte
   input  wire logic                clk_release_i,  // release held clock
   output logic                     sdo_o,          // serial data out
   output logic                     sdo_oe_o,       // serial data out enable
   output logic                     scl_o,          // i2c clock drive level
   output logic                     scl_oe_o,       // i2c clock hold low
   output logic                     sda_o,          // i2c data drive level
   output logic                     sda_oe_o,       // i2c data drive low
   output logic [7:0]               buf_rdata_o,    // shift_buffer contents
   output logic                     buf_full_o,     // unread byte present
   output logic                     overflow_o,     // byte lost, buffer full
   output logic                     wr_coll_o,      // write refused
   output logic                     byte_done_flag_o, // sticky event flag
   output logic                     wake_o,         // wake request
   output logic                     sck_level_o,    // synced clock pin
   output ssc_pkg::ssc_i2c_stat_t   i2c_stat_o,     // i2c condition status
   output logic                     slave_rst_o,    // one-cycle slave reset
   output logic                     tx_prep_o       // transmit data wanted
);
   import ssc_pkg::*;

   function automatic logic native_cond_irq(input logic [3:0] m);
      native_cond_irq = (m == `SSC_MODE_I2C_S7_SP) || (m == `SSC_MODE_I2C_S10_SP)
                        || (m == `SSC_MODE_I2C_FWM);
   endfunction : native_cond_irq
   // ---------------- system side configuration
   logic spi_on;
   logic ss_ctl;
   logic i2c_on;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spi_on <= 1'b0;
         ss_ctl <= 1'b0;
         i2c_on <= 1'b0;
      end else begin
         spi_on <= cfg_i.port_enable_bit &&
                   (cfg_i.mode == `SSC_MODE_SPI_SS || cfg_i.mode == `SSC_MODE_SPI_NOSS);
         ss_ctl <= cfg_i.port_enable_bit && (cfg_i.mode == `SSC_MODE_SPI_SS);
         i2c_on <= cfg_i.port_enable_bit && !spi_on &&
                   (cfg_i.mode[1] || cfg_i.mode[3]);
      end
   end

   // raw pin acts as async reset so release is immediate
   logic link_off;
   assign link_off = !rst_n_i || !spi_on || (ss_ctl && ss_n_i);

   always_ff @(posedge clock_i or posedge link_off) begin
      if (link_off) begin
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= 1'b1;
      end
   end

   // ---------------- link domain: shifter on the external clock
   // edge select swaps sample edge; clock gating kept to two xors
   logic lclk;
   assign lclk = sck_i ^ cfg_i.clock_idle_polarity ^ cfg_i.clock_edge_sel;

   logic [2:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] rx_word;
   logic       done_tgl;
   logic       tx_ack;
   logic       txr_m;
   logic       txr_s;
   logic       tx_req;
   logic [7:0] tx_hold;
   // handshake state outlives link resets, else a reset fakes a byte or replays a write
   always_ff @(posedge lclk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txr_m    <= 1'b0;
         txr_s    <= 1'b0;
         done_tgl <= 1'b0;
         tx_ack   <= 1'b0;
      end else begin
         txr_m <= tx_req;
         txr_s <= txr_m;
         if (bit_cnt == `SSC_BIT_LAST) begin
            done_tgl <= !done_tgl;
            tx_ack   <= txr_s;
         end
      end
   end

   always_ff @(posedge lclk or posedge link_off) begin
      if (link_off) begin
         bit_cnt <= `SSC_BIT_ZERO;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end
   // unloaded shifter keeps received bits, so next byte echoes them
   always_ff @(posedge lclk or posedge link_off) begin
      if (link_off) begin
         shreg    <= `SSC_BYTE_RST;
         rx_word  <= `SSC_BYTE_RST;
      end else if (bit_cnt == `SSC_BIT_LAST) begin
         rx_word  <= {shreg[6:0], sdi_i};
         if (txr_s != tx_ack) begin
            shreg  <= tx_hold;
         end else begin
            shreg  <= {shreg[6:0], sdi_i};
         end
      end else begin
         shreg <= {shreg[6:0], sdi_i};
      end
   end

   always_ff @(negedge lclk or posedge link_off) begin
      if (link_off) begin
         sdo_o <= 1'b0;
      end else begin
         sdo_o <= shreg[7];
      end
   end

   // ---------------- crossings into the system domain
   logic done_m;
   logic done_s;
   logic done_p;
   logic sck_m;
   logic rx_evt;
   assign rx_evt = done_s != done_p;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_m      <= 1'b0;
         done_s      <= 1'b0;
         done_p      <= 1'b0;
         sck_m       <= 1'b0;
         sck_level_o <= 1'b0;
      end else begin
         done_m      <= done_tgl;
         done_s      <= done_m;
         done_p      <= done_s;
         sck_m       <= sck_i;
         sck_level_o <= sck_m;
      end
   end

   // ---------------- shift_buffer, software side
   logic wr_ok;
   assign wr_ok = !buf_full_o || cfg_i.buffer_overwrite_enable || buf_rd_i;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         buf_rdata_o <= `SSC_BYTE_RST;
         buf_full_o  <= 1'b0;
         overflow_o  <= 1'b0;
      end else begin
         if (rx_evt && (!buf_full_o || cfg_i.buffer_overwrite_enable)) begin
            buf_rdata_o <= rx_word;
         end
         if (rx_evt) begin
            buf_full_o <= 1'b1;
         end else if (buf_rd_i) begin
            buf_full_o <= 1'b0;
         end
         if (rx_evt && buf_full_o && !buf_rd_i && !cfg_i.buffer_overwrite_enable) begin
            overflow_o <= 1'b1;
         end else if (!cfg_i.port_enable_bit) begin
            overflow_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_req    <= 1'b0;
         tx_hold   <= `SSC_BYTE_RST;
         wr_coll_o <= 1'b0;
      end else if (buf_wr_i && wr_ok) begin
         tx_hold <= buf_wdata_i;
         tx_req  <= !tx_req;
      end else if (buf_wr_i) begin
         wr_coll_o <= 1'b1;
      end else if (!cfg_i.port_enable_bit) begin
         wr_coll_o <= 1'b0;
      end
   end

   // ---------------- i2c conditions
   logic scl_m;
   logic scl_s;
   logic sda_m;
   logic sda_s;
   logic sda_p;
   logic scl_low_seen;
   logic start_evt;
   logic stop_evt;
   ssc_bus_t bus_st;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   assign start_evt = i2c_on && scl_s && sda_p && !sda_s;
   assign stop_evt  = i2c_on && scl_s && !sda_p && sda_s && scl_low_seen;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_low_seen <= 1'b0;
      end else if (!i2c_on || start_evt || stop_evt) begin
         scl_low_seen <= 1'b0;
      end else if (!scl_s) begin
         scl_low_seen <= 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_st <= SSC_BUS_IDLE;
      end else begin
         case (bus_st)
            SSC_BUS_IDLE:  bus_st <= start_evt ? SSC_BUS_START : SSC_BUS_IDLE;
            SSC_BUS_START: bus_st <= stop_evt ? SSC_BUS_IDLE : SSC_BUS_BUSY;
            SSC_BUS_BUSY:  bus_st <= stop_evt ? SSC_BUS_IDLE :
                                     (start_evt ? SSC_BUS_START : SSC_BUS_BUSY);
            default:       bus_st <= SSC_BUS_IDLE;
         endcase
         if (!i2c_on) begin
            bus_st <= SSC_BUS_IDLE;
         end
      end
   end

   // start and restart both clear the slave
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slave_rst_o <= 1'b0;
      end else begin
         slave_rst_o <= start_evt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         i2c_stat_o <= '0;
      end else begin
         i2c_stat_o.bus_active <= (bus_st != SSC_BUS_IDLE) || start_evt;
         if (!i2c_on) begin
            i2c_stat_o.start_seen <= 1'b0;
            i2c_stat_o.stop_seen  <= 1'b0;
         end else if (start_evt) begin
            i2c_stat_o.start_seen <= 1'b1;
            i2c_stat_o.stop_seen  <= 1'b0;
         end else if (stop_evt) begin
            i2c_stat_o.start_seen <= 1'b0;
            i2c_stat_o.stop_seen  <= 1'b1;
         end
         if (start_gen_i && (!sda_s || !scl_s)) begin
            i2c_stat_o.collision <= 1'b1;
         end else if (bcol_clr_i) begin
            i2c_stat_o.collision <= 1'b0;
         end
         if (full_match_i && !rw_i) begin
            i2c_stat_o.prior_match <= 1'b1;
         end else if (stop_evt || (high_byte_i && (!rw_i || !high_match_i))) begin
            i2c_stat_o.prior_match <= 1'b0;
         end
      end
   end

   logic read_go;
   assign read_go = high_byte_i && high_match_i && rw_i && i2c_stat_o.prior_match;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_o     <= 1'b0;
         scl_oe_o  <= 1'b0;
         tx_prep_o <= 1'b0;
      end else if (read_go) begin
         scl_oe_o  <= 1'b1;
         tx_prep_o <= 1'b1;
      end else if (clk_release_i || !i2c_on) begin
         scl_oe_o  <= 1'b0;
         tx_prep_o <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_o    <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (start_gen_i && sda_s && scl_s && i2c_on) begin
         sda_oe_o <= 1'b1;
      end else if (sda_release_i || !i2c_on) begin
         sda_oe_o <= 1'b0;
      end
   end

   // ---------------- event flag and wake
   logic cond_irq;
   assign cond_irq = native_cond_irq(cfg_i.mode) ?
                     (start_evt || stop_evt) :
                     ((start_evt && cfg_i.start_irq_enable) ||
                      (stop_evt && cfg_i.stop_irq_enable));

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_done_flag_o <= 1'b0;
         wake_o           <= 1'b0;
      end else begin
         if (rx_evt || cond_irq) begin
            byte_done_flag_o <= 1'b1;
         end else if (flag_clr_i) begin
            byte_done_flag_o <= 1'b0;
         end
         wake_o <= sleep_irq_en_i && (byte_done_flag_o || rx_evt);
      end
   end
endmodule : ssc_top

//--- bench/ssc_chk.sv
`timescale 1ns/100ps
`include "ssc_cfg.svh"
module ssc_chk
   import ssc_pkg::*;
(
   input wire logic                   clock_i,          // clock
   input wire logic                   rst_n_i,          // reset
   input wire ssc_pkg::ssc_cfg_t      cfg_i,            // config
   input wire logic                   ss_n_i,           // select
   input wire logic                   sleep_irq_en_i,   // wake enable
   input wire logic                   flag_clr_i,       // flag clear
   input wire logic                   buf_wr_i,         // buffer write
   input wire logic                   buf_rd_i,         // buffer read
   input wire logic                   full_match_i,     // full match
   input wire logic                   high_byte_i,      // high byte
   input wire logic                   high_match_i,     // high match
   input wire logic                   rw_i,             // direction
   input wire logic                   sdo_oe_o,         // data out enable
   input wire logic                   scl_oe_o,         // clock hold
   input wire logic                   buf_full_o,       // unread byte
   input wire logic                   wr_coll_o,        // write refused
   input wire logic                   byte_done_flag_o, // event flag
   input wire logic                   wake_o,           // wake
   input wire ssc_pkg::ssc_i2c_stat_t i2c_stat_o,       // i2c status
   input wire logic                   slave_rst_o,      // slave reset
   input wire logic                   tx_prep_o         // transmit wanted
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   logic ss_mode;
   logic ten_bit;
   assign ss_mode = cfg_i.port_enable_bit && cfg_i.mode == `SSC_MODE_SPI_SS;
   assign ten_bit = cfg_i.port_enable_bit && cfg_i.mode == `SSC_MODE_I2C_S10;
   chk_ss_release: assert property (ss_mode && ss_n_i |-> !sdo_oe_o)
      else $error("data output driven while deselected");
   chk_sel_drive: assert property ((ss_mode && !ss_n_i) [*3] |-> sdo_oe_o)
      else $error("data output not driven while selected");
   // a config change may legally drop the flag
   chk_flag_hold: assert property (cfg_i.port_enable_bit && byte_done_flag_o && !flag_clr_i
      |=> byte_done_flag_o || !$stable(cfg_i)) else $error("byte flag lost");
   chk_wake_follow: assert property (sleep_irq_en_i && byte_done_flag_o |-> ##[0:2] wake_o)
      else $error("no wake after byte");
   chk_wcol_set: assert property (cfg_i.port_enable_bit && buf_wr_i && buf_full_o &&
      !cfg_i.buffer_overwrite_enable && !buf_rd_i |=> wr_coll_o) else $error("write not refused");
   chk_prior_set: assert property (ten_bit && full_match_i && !rw_i |=> i2c_stat_o.prior_match)
      else $error("prior match not set");
   chk_prior_drop: assert property (ten_bit && high_byte_i && !(high_match_i && rw_i)
      && !full_match_i |=> !i2c_stat_o.prior_match) else $error("prior match not cleared");
   chk_clock_hold: assert property (ten_bit && high_byte_i && high_match_i && rw_i
      && i2c_stat_o.prior_match |=> scl_oe_o && tx_prep_o) else $error("clock not held");
   chk_rst_pulse: assert property (slave_rst_o |=> !slave_rst_o)
      else $error("slave reset longer than one cycle");
   cov_byte: cover property ($rose(byte_done_flag_o));
   cov_hold: cover property ($rose(tx_prep_o));
   cov_coll: cover property ($rose(i2c_stat_o.collision));
endmodule : ssc_chk
bind ssc_top ssc_chk chk_u (
   .clock_i, .rst_n_i, .cfg_i, .ss_n_i, .sleep_irq_en_i, .flag_clr_i, .buf_wr_i, .buf_rd_i,
   .full_match_i, .high_byte_i, .high_match_i, .rw_i, .sdo_oe_o, .scl_oe_o, .buf_full_o,
   .wr_coll_o, .byte_done_flag_o, .wake_o, .i2c_stat_o, .slave_rst_o, .tx_prep_o
);

//--- bench/ssc_spi_mst.sv
`timescale 1ns/100ps
module ssc_spi_mst (
   output logic      sck_o,  // serial clock
   output logic      ss_n_o, // slave select
   output logic      mosi_o, // data to slave
   input  wire logic miso_i  // data from slave, pulled up
);
   logic pol = 1'b0;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // park clock at idle before the port is enabled
   task automatic idle(input logic p);
      pol = p;
      sck_o = p;
   endtask : idle
   task automatic sel;
      #5 ss_n_o = 1'b0;
      #32;
   endtask : sel
   // msb first, data set half a period before the sampling edge
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         mosi_o = tx[7 - i];
         #16 sck_o = ~pol;
         rx = {rx[6:0], miso_i};
         #16 sck_o = pol;
      end
   endtask : xfer
   // released line shows the inverse, never a stale copy
   task automatic desel;
      #16 ss_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask : desel
endmodule : ssc_spi_mst

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
   import ssc_pkg::*;
   localparam logic [11:0] FCLR = 12'h001, BWR = 12'h002, BRD = 12'h004, SGEN = 12'h008;
   localparam logic [11:0] SREL = 12'h010, BCLR = 12'h020, FM = 12'h040, HB = 12'h080;
   localparam logic [11:0] HM = 12'h100, RW = 12'h200, CREL = 12'h400;
   logic          clock_i = 1'b0;
   logic          rst_n_i = 1'b0;
   ssc_cfg_t      cfg = '0;
   logic [11:0]   ev = 12'h000;
   logic [7:0]    bwd = 8'h77;
   logic [7:0]    rx;
   logic [7:0]    rdata;
   logic          scl = 1'b1;
   logic          sda = 1'b1;
   logic          sck, ss_n, mosi, sdo, sdo_oe, scl_oe, sda_oe, sckl;
   logic          bfull, ovf, wcol, bdf, wake, srst, txp, scl_lvl, sda_lvl;
   ssc_i2c_stat_t st;
   int            fail_count = 0;
   int            checked = 0;
   int            nrst = 0;
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) if (srst === 1'b1) nrst <= nrst + 1;
   ssc_spi_mst mst_u (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(sdo_oe ? sdo : 1'b1));
   ssc_top dut_u (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .sleep_irq_en_i(ev[11]),
      .flag_clr_i(ev[0]), .buf_wr_i(ev[1]), .buf_wdata_i(bwd), .buf_rd_i(ev[2]),
      .sck_i(sck), .ss_n_i(ss_n), .sdi_i(mosi), .scl_i(scl & ~scl_oe), .sda_i(sda & ~sda_oe),
      .start_gen_i(ev[3]), .sda_release_i(ev[4]), .bcol_clr_i(ev[5]), .full_match_i(ev[6]),
      .high_byte_i(ev[7]), .high_match_i(ev[8]), .rw_i(ev[9]), .clk_release_i(ev[10]),
      .sdo_o(sdo), .sdo_oe_o(sdo_oe), .scl_o(scl_lvl), .scl_oe_o(scl_oe),
      .sda_o(sda_lvl), .sda_oe_o(sda_oe),
      .buf_rdata_o(rdata), .buf_full_o(bfull), .overflow_o(ovf), .wr_coll_o(wcol),
      .byte_done_flag_o(bdf), .wake_o(wake), .sck_level_o(sckl), .i2c_stat_o(st),
      .slave_rst_o(srst), .tx_prep_o(txp));
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : cmp
   // checks land 1 ns after the edge, once its updates settled
   task automatic tk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tk
   task automatic pulse(input logic [11:0] m);
      @(posedge clock_i) ev <= ev | m;
      @(posedge clock_i) ev <= ev & ~m;
   endtask : pulse
   task automatic wflag;
      int i;
      for (i = 0; i < 40 && bdf !== 1'b1; i++) tk(1);
      if (i == 40) begin
         fail_count++;
         summarize();
      end
   endtask : wflag
   task automatic spi(input logic [7:0] tx);
      pulse(FCLR);
      mst_u.xfer(tx, 8, rx);
      wflag();
   endtask : spi
   // synchroniser needs a few clocks per pin change
   task automatic bus(input logic [1:0] cd);
      @(posedge clock_i) scl <= cd[1];
      sda <= cd[0];
      tk(5);
   endtask : bus
   initial begin
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      tk(2);
      cmp({sdo_oe, bdf, wcol, ovf, bfull, wake, srst, txp, 3'h0, st}, 16'h0000);
      @(posedge clock_i) cfg <= {4'h4, 6'b100000};
      tk(3);
      cmp(sdo_oe, 1'b0);
      mst_u.sel();
      tk(2);
      cmp(sdo_oe, 1'b1);
      spi(8'hA5);
      cmp({bfull, rdata}, 9'h1A5);
      pulse(BRD);
      spi(8'h3C);
      cmp(rx, 8'hA5);
      spi(8'hC3);
      tk(4);
      cmp({ovf, rdata}, 9'h13C);
      pulse(BWR);
      tk(1);
      cmp(wcol, 1'b1);
      mst_u.xfer(8'h0F, 4, rx);
      mst_u.desel();
      #1;
      cmp(sdo_oe, 1'b0);
      @(posedge clock_i) cfg.port_enable_bit <= 1'b0;
      pulse(FCLR);
      tk(1);
      cmp({wcol, ovf, sdo_oe}, 3'b000);
      mst_u.idle(1'b1);
      @(posedge clock_i) cfg <= {4'h4, 6'b110100};
      ev[11] <= 1'b1;
      tk(3);
      cmp(sckl, 1'b1);
      mst_u.sel();
      spi(8'h5A);
      cmp(rdata, 8'h5A);
      tk(3);
      cmp(wake, 1'b1);
      pulse(BWR);
      tk(1);
      cmp(wcol, 1'b0);
      mst_u.xfer(8'h11, 8, rx);
      mst_u.xfer(8'h22, 8, rx);
      cmp(rx, 8'h77);
      tk(8);
      cmp(rdata, 8'h22);
      mst_u.desel();
      @(posedge clock_i) cfg.port_enable_bit <= 1'b0;
      mst_u.idle(1'b0);
      @(posedge clock_i) cfg <= {4'h5, 6'b100000};
      tk(3);
      cmp(sdo_oe, 1'b1);
      @(posedge clock_i) cfg.port_enable_bit <= 1'b0;
      pulse(FCLR);
      @(posedge clock_i) cfg <= {4'h6, 6'b100010};
      tk(3);
      bus(2'b10);
      cmp({st.start_seen, st.bus_active, bdf}, 3'b111);
      bus(2'b11);
      cmp(st.stop_seen, 1'b0);
      bus(2'b10);
      bus(2'b00);
      bus(2'b01);
      bus(2'b11);
      bus(2'b10);
      cmp(nrst[7:0], 8'h03);
      pulse(FCLR);
      bus(2'b00);
      bus(2'b10);
      bus(2'b11);
      cmp({st.stop_seen, bdf}, 2'b10);
      bus(2'b10);
      pulse(SGEN);
      tk(2);
      cmp(st.collision, 1'b1);
      pulse(BCLR);
      bus(2'b11);
      pulse(SGEN);
      tk(1);
      cmp({st.collision, sda_oe}, 2'b01);
      pulse(SREL);
      @(posedge clock_i) cfg.mode <= 4'h7;
      pulse(FM);
      tk(1);
      cmp(st.prior_match, 1'b1);
      pulse(HB | HM | RW);
      tk(4);
      cmp({scl_lvl, sda_lvl, scl_oe, txp}, 4'b0011);
      pulse(CREL);
      tk(1);
      cmp({scl_oe, txp}, 2'b00);
      pulse(HB | HM);
      tk(1);
      cmp(st.prior_match, 1'b0);
      summarize();
   end
endmodule : testbench
